/* rtl/pmrc_pkg.sv */
// Functional notes
// - idle bit 0 set halts cpu after the writing instruction; clocks keep running.
// - idle keeps all registers and memory unchanged; peripherals may stay active.
// - enabled interrupt during idle clears idle bit and resumes cpu.
// - reset ending idle or stop runs normal reset, fetch from zero.
// - enabled watchdog reset ends idle; software may disable it first.
// - stop bit 1 halts internal oscillator, cpu and digital peripherals.
// - stop ignores interrupts; only internal or external reset ends it.
// - clock loss detector stays active in stop and may reset device.
// - with regulator stop shutdown set, only reset pin, supply monitor or power cycle resets.
// - reset halts execution, loads register reset values, disables interrupts and timers.
// - reset keeps data memory but reinitialises the stack pointer.
// - reset loads port latches with all ones, open-drain, pull-ups enabled.
// - power-on and supply-monitor resets drive the reset pin low throughout.
// - reset exit clears program counter and selects internal oscillator.
// - after any reset watchdog is enabled, clocked at system clock over twelve.
// - power-up holds reset and adds a release delay before leaving reset.
// - power-on exit sets the power-up cause flag.
// - every other reset clears the power-up cause flag.
// - after power-on, data memory undefined and supply monitor enabled.
// - supply monitor enable is set only by power-on reset.
package pmrc_pkg;
  localparam logic [7:0] PMC_ADDR = 8'h87;
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam logic [7:0] PMC_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam int WDT_DIV = 12;
  localparam int CLK_MHZ = 20;
  localparam int POR_DELAY_US = 300;
  localparam int POR_CYCLES = POR_DELAY_US * CLK_MHZ;
  localparam int CLD_TIMEOUT_US = 100;
  localparam int CLD_CYCLES = CLD_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_STOP} pmrc_mode_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic instr_done;
  } pmrc_sfr_t;

  typedef struct packed {
    logic por;
    logic pin;
    logic vmon;
    logic wdt;
    logic other;
  } pmrc_rst_t;
endpackage

/* rtl/pmrc_top.sv */
`timescale 1ns/1ps
module pmrc_top #(
  parameter int POR_CNT = pmrc_pkg::POR_CYCLES,
  parameter int CLD_CNT = pmrc_pkg::CLD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rst_pin_n,
  input wire pmrc_pkg::pmrc_sfr_t sfr,
  input wire logic [7:0] sfr_raddr,
  input wire logic irq_pending,
  input wire logic irq_enable,
  input wire logic vmon_fail,
  input wire logic wdt_fire,
  input wire logic other_rst,
  input wire logic cld_en,
  input wire logic reg_stop_shutdown,
  input wire logic wdt_disable,
  output logic [7:0] sfr_rdata,
  output logic cpu_halt,
  output logic osc_stop,
  output logic periph_halt,
  output logic sys_rst_n,
  output logic rst_pin_oe,
  output logic rst_pin_o,
  output logic power_up_cause_flag,
  output logic vmon_en,
  output logic wdt_en,
  output logic wdt_tick,
  output logic [15:0] program_counter,
  output logic [7:0] stack_ptr,
  output logic [7:0] port_latch,
  output logic pullup_en,
  output logic int_osc_sel
);
  // ***************************************************
  // pin synchronisers and internal reset release
  // ***************************************************
  logic [1:0] pin_sync_r;
  logic [1:0] pin_sync_nxt;
  logic [1:0] rel_sync_r;
  logic [1:0] rel_sync_nxt;
  logic pin_rst;
  logic any_rst;

  always_comb begin
    pin_sync_nxt = {pin_sync_r[0], rst_pin_n};
    rel_sync_nxt = {rel_sync_r[0], 1'b1};
  end

  // first flop only feeds the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_r <= 2'b00;
      rel_sync_r <= 2'b00;
    end else begin
      pin_sync_r <= pin_sync_nxt;
      rel_sync_r <= rel_sync_nxt;
    end
  end

  assign pin_rst = !pin_sync_r[1];

  // ***************************************************
  // reset sequencer
  // ***************************************************
  logic por_done_r;
  logic por_done_nxt;
  logic [31:0] por_cnt_r;
  logic [31:0] por_cnt_nxt;
  logic [31:0] cld_cnt_r;
  logic [31:0] cld_cnt_nxt;
  logic cld_rst;
  logic wdt_rst;
  logic soft_rst;
  logic in_rst_r;
  logic in_rst_nxt;
  logic pin_drive_nxt;
  logic puf_nxt;
  logic vmon_en_nxt;
  logic vmon_hold_nxt;
  logic pin_echo_r;
  logic pin_echo_nxt;
  logic cause_rst;
  pmrc_pkg::pmrc_mode_t mode_r;
  pmrc_pkg::pmrc_mode_t mode_nxt;

  // regulator shutdown in stop blocks watchdog, detector and other internal sources, not the supply monitor
  assign soft_rst = (mode_r == pmrc_pkg::ST_STOP) && reg_stop_shutdown;
  assign cld_rst = cld_en && (cld_cnt_r == CLD_CNT - 1) && !soft_rst;
  assign wdt_rst = wdt_fire && wdt_en && !soft_rst;
  assign any_rst = pin_rst || (vmon_fail && vmon_en) || cld_rst || wdt_rst || (other_rst && !soft_rst);
  // our own pin drive comes back through the synchroniser; it must not count as a new reset cause
  assign cause_rst = (pin_rst && !pin_echo_r) || (vmon_fail && vmon_en) || cld_rst || wdt_rst
    || (other_rst && !soft_rst);

  always_comb begin
    por_done_nxt = por_done_r;
    por_cnt_nxt = por_cnt_r;
    cld_cnt_nxt = 32'h0000_0000;
    // power-up delay before first release
    if (!por_done_r) begin
      if (por_cnt_r == POR_CNT - 1) begin
        por_done_nxt = 1'b1;
      end else begin
        por_cnt_nxt = por_cnt_r + 32'h0000_0001;
      end
    end
    // detector model: system clock stopped only while in stop
    if (mode_r == pmrc_pkg::ST_STOP && cld_en && cld_cnt_r != CLD_CNT - 1) begin
      cld_cnt_nxt = cld_cnt_r + 32'h0000_0001;
    end
    in_rst_nxt = !por_done_nxt || any_rst;
    vmon_hold_nxt = vmon_fail && vmon_en;
    // echo lasts while driving and until the synchronised pin reads high again
    pin_echo_nxt = rst_pin_oe || (pin_echo_r && !pin_sync_r[1]);
    // pin driven low only for power-on and supply-monitor resets
    pin_drive_nxt = !por_done_nxt || vmon_hold_nxt;
    puf_nxt = power_up_cause_flag;
    if (!por_done_r) begin
      puf_nxt = 1'b1;
    end else if (cause_rst) begin
      puf_nxt = 1'b0;
    end
    vmon_en_nxt = vmon_en;
    if (!por_done_r) begin
      vmon_en_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_done_r <= 1'b0;
      por_cnt_r <= 32'h0000_0000;
      cld_cnt_r <= 32'h0000_0000;
      in_rst_r <= 1'b1;
      pin_echo_r <= 1'b1;
      rst_pin_oe <= 1'b1;
      rst_pin_o <= 1'b0;
      power_up_cause_flag <= 1'b1;
      vmon_en <= 1'b1;
    end else begin
      por_done_r <= por_done_nxt;
      por_cnt_r <= por_cnt_nxt;
      cld_cnt_r <= cld_cnt_nxt;
      in_rst_r <= in_rst_nxt;
      pin_echo_r <= pin_echo_nxt;
      rst_pin_oe <= pin_drive_nxt;
      rst_pin_o <= 1'b0;
      power_up_cause_flag <= puf_nxt;
      vmon_en <= vmon_en_nxt;
    end
  end

  // ***************************************************
  // power mode control register and mode machine
  // ***************************************************
  logic [5:0] gp_flags_r;
  logic [5:0] gp_flags_nxt;
  logic wdt_en_nxt;
  logic [3:0] wdt_div_r;
  logic [3:0] wdt_div_nxt;
  logic pmc_wr;

  assign pmc_wr = sfr.wr && sfr.addr == pmrc_pkg::PMC_ADDR;

  always_comb begin
    mode_nxt = mode_r;
    gp_flags_nxt = gp_flags_r;
    wdt_en_nxt = wdt_en && !wdt_disable;
    wdt_div_nxt = wdt_div_r;
    if (in_rst_r || !rel_sync_r[1]) begin
      mode_nxt = pmrc_pkg::ST_RUN;
      gp_flags_nxt = pmrc_pkg::PMC_RESET[7:2];
      wdt_en_nxt = 1'b1;
      wdt_div_nxt = 4'h0;
    end else begin
      unique case (mode_r)
        pmrc_pkg::ST_RUN: begin
          if (pmc_wr) begin
            gp_flags_nxt = sfr.data[7:2];
            // stop wins if both select bits are written; mode taken once the instruction ends
            if (sfr.instr_done && sfr.data[pmrc_pkg::STOP_BIT]) begin
              mode_nxt = pmrc_pkg::ST_STOP;
            end else if (sfr.instr_done && sfr.data[pmrc_pkg::IDLE_BIT]) begin
              mode_nxt = pmrc_pkg::ST_IDLE;
            end
          end
        end
        pmrc_pkg::ST_IDLE: begin
          if (irq_pending && irq_enable) begin
            mode_nxt = pmrc_pkg::ST_RUN;
          end
        end
        pmrc_pkg::ST_STOP: begin
          mode_nxt = pmrc_pkg::ST_STOP;
        end
      endcase
      // divide by twelve tick, frozen in stop
      if (mode_r != pmrc_pkg::ST_STOP) begin
        wdt_div_nxt = (wdt_div_r == 4'(pmrc_pkg::WDT_DIV - 1)) ? 4'h0 : wdt_div_r + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= pmrc_pkg::ST_RUN;
      gp_flags_r <= 6'h00;
      wdt_en <= 1'b1;
      wdt_div_r <= 4'h0;
    end else begin
      mode_r <= mode_nxt;
      gp_flags_r <= gp_flags_nxt;
      wdt_en <= wdt_en_nxt;
      wdt_div_r <= wdt_div_nxt;
    end
  end

  // ***************************************************
  // registered outputs
  // ***************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
      cpu_halt <= 1'b1;
      osc_stop <= 1'b0;
      periph_halt <= 1'b1;
      sys_rst_n <= 1'b0;
      wdt_tick <= 1'b0;
      program_counter <= pmrc_pkg::PC_RESET;
      stack_ptr <= pmrc_pkg::SP_RESET;
      port_latch <= pmrc_pkg::PORT_RESET;
      pullup_en <= 1'b1;
      int_osc_sel <= 1'b1;
    end else begin
      // select bits read back as zero
      sfr_rdata <= (sfr_raddr == pmrc_pkg::PMC_ADDR) ? {gp_flags_r, 2'b00} : 8'h00;
      cpu_halt <= in_rst_nxt || mode_nxt != pmrc_pkg::ST_RUN;
      osc_stop <= mode_nxt == pmrc_pkg::ST_STOP;
      periph_halt <= in_rst_nxt || mode_nxt == pmrc_pkg::ST_STOP;
      sys_rst_n <= !in_rst_r && rel_sync_r[1];
      // divider freezes in stop, so a frozen terminal count must not tick every cycle
      wdt_tick <= wdt_en && mode_r != pmrc_pkg::ST_STOP && wdt_div_r == 4'(pmrc_pkg::WDT_DIV - 1);
      if (in_rst_r) begin
        program_counter <= pmrc_pkg::PC_RESET;
        stack_ptr <= pmrc_pkg::SP_RESET;
        port_latch <= pmrc_pkg::PORT_RESET;
        int_osc_sel <= 1'b1;
      end
      pullup_en <= 1'b1;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  sequence s_idle_wake;
    mode_r == pmrc_pkg::ST_IDLE && irq_pending && irq_enable && !in_rst_r && rel_sync_r[1];
  endsequence

  property p_idle_enter;
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_r == pmrc_pkg::ST_RUN && !in_rst_r && rel_sync_r[1] && pmc_wr && sfr.instr_done && sfr.data[0]
      && !sfr.data[1] && !any_rst) |=> mode_r == pmrc_pkg::ST_IDLE && cpu_halt;
  endproperty
  a_idle_enter: assert property (p_idle_enter) else $error("idle not entered");

  property p_idle_wake;
    @(posedge ref_clk) disable iff (!rst_n)
    s_idle_wake ##1 !any_rst |-> mode_r == pmrc_pkg::ST_RUN;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not left on interrupt");

  property p_stop_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    mode_r == pmrc_pkg::ST_STOP && !in_rst_r |=> mode_r == pmrc_pkg::ST_STOP || $past(in_rst_r) || in_rst_r;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");

  property p_read_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> sfr_rdata[1:0] == 2'b00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("select bits read nonzero");

  property p_puf_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    por_done_r && any_rst && !pin_echo_r |=> !power_up_cause_flag;
  endproperty
  a_puf_clear: assert property (p_puf_clear) else $error("cause flag not cleared");

  property p_pin_por;
    @(posedge ref_clk) disable iff (!rst_n)
    !por_done_r ##1 !por_done_r |-> rst_pin_oe && !rst_pin_o && !sys_rst_n;
  endproperty
  a_pin_por: assert property (p_pin_por) else $error("pin not driven in power-up");

  property p_wdt_div;
    @(posedge ref_clk) disable iff (!rst_n)
    wdt_tick |=> !wdt_tick [*8];
  endproperty
  a_wdt_div: assert property (p_wdt_div) else $error("watchdog tick too fast");

  property p_pc_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    in_rst_r |=> program_counter == pmrc_pkg::PC_RESET && port_latch == pmrc_pkg::PORT_RESET;
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("reset values not loaded");
endmodule

/* sim/pmrc_ext_rst.sv */
`timescale 1ns/1ps
// ****************************************
// external reset circuitry on the reset pin
// ****************************************
module pmrc_ext_rst (
  input wire logic press,
  input wire logic drv_oe,
  input wire logic drv_o,
  output logic pin_n
);
  // open-drain wired-and with pull-up, so a released pin reads high, never stale
  assign pin_n = !(press || (drv_oe && !drv_o));
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, rst_n = 1'b0, press = 1'b0, pin_n;
  pmrc_pkg::pmrc_sfr_t sfr = '0;
  logic [7:0] sfr_raddr = 8'h00;
  logic irq_pending = 1'b0, irq_enable = 1'b0, vmon_fail = 1'b0, wdt_fire = 1'b0, other_rst = 1'b0;
  logic cld_en = 1'b0, reg_stop_shutdown = 1'b0, wdt_disable = 1'b0;
  logic [7:0] sfr_rdata, stack_ptr, port_latch, rv, d, sp0;
  logic [15:0] program_counter;
  logic cpu_halt, osc_stop, periph_halt, sys_rst_n, rst_pin_oe, rst_pin_o, power_up_cause_flag;
  logic vmon_en, wdt_en, wdt_tick, pullup_en, int_osc_sel;
  int failures = 0, compares = 0, n;
  // ****************************************
  // design, reset pin and clock
  // ****************************************
  // short counts keep the run brief; expectations below use the same values
  pmrc_top #(.POR_CNT(20), .CLD_CNT(10)) i_dut (.ref_clk, .rst_n, .rst_pin_n(pin_n), .sfr, .sfr_raddr,
    .irq_pending, .irq_enable, .vmon_fail, .wdt_fire, .other_rst, .cld_en, .reg_stop_shutdown,
    .wdt_disable, .sfr_rdata, .cpu_halt, .osc_stop, .periph_halt, .sys_rst_n, .rst_pin_oe, .rst_pin_o,
    .power_up_cause_flag, .vmon_en, .wdt_en, .wdt_tick, .program_counter, .stack_ptr, .port_latch,
    .pullup_en, .int_osc_sel);
  pmrc_ext_rst i_ext (.press, .drv_oe(rst_pin_oe), .drv_o(rst_pin_o), .pin_n);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // one-cycle write strobe, dropped at the next falling edge
  task automatic wr(input logic [7:0] v);
    sfr = {1'b1, pmrc_pkg::PMC_ADDR, v, 1'b1};
    cyc(1);
    sfr.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_raddr = a;
    cyc(1);
    rv = sfr_rdata;
  endtask
  // bounded wait for the internal reset to lift
  task automatic waitsys;
    n = 0;
    while (sys_rst_n !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] v);
    return v & 8'hFC;
  endfunction
  task automatic por;
    rst_n = 1'b0;
    cyc(10);
    chk("halt", {cpu_halt, periph_halt, sys_rst_n}, 16'h0006);
    chk("pin", {rst_pin_oe, pin_n}, 16'h0002);
    chk("port", {pullup_en, port_latch}, 16'h01FF);
    chk("pc", program_counter, pmrc_pkg::PC_RESET);
    chk("sp", stack_ptr, pmrc_pkg::SP_RESET);
    chk("vmon", {power_up_cause_flag, vmon_en}, 16'h0003);
    rst_n = 1'b1;
    waitsys;
    chk("release", sys_rst_n, 16'h0001);
    chk("delay", 16'(n >= 20), 16'h0001);
    chk("flag", power_up_cause_flag, 16'h0001);
    chk("osc", {int_osc_sel, wdt_en, rst_pin_oe, pullup_en}, 16'h000D);
    $display("test power_on done");
  endtask
  task automatic summarize;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(99537));
    por;
    n = 0;
    repeat (24) begin
      cyc(1);
      n += wdt_tick;
    end
    chk("tick", n[15:0], 16'h0002);
    // random flag bytes, mode bits kept clear so the cpu stays running
    repeat (8) begin
      d = 8'($urandom) & 8'hFC;
      wr(d);
      rd(pmrc_pkg::PMC_ADDR);
      chk("gp", rv, exp_rd(d));
    end
    sp0 = stack_ptr;
    // no register write follows the idle write, as a two-byte filler would behave
    wr(8'hFD);
    cyc(2);
    chk("idle", {cpu_halt, osc_stop, periph_halt}, 16'h0004);
    irq_pending = 1'b1;
    cyc(4);
    chk("masked", cpu_halt, 16'h0001);
    chk("keep", stack_ptr, sp0);
    irq_enable = 1'b1;
    cyc(3);
    chk("wake", cpu_halt, 16'h0000);
    irq_pending = 1'b0;
    rd(pmrc_pkg::PMC_ADDR);
    chk("rd", rv, 8'hFC);
    $display("test idle done");
    wdt_disable = 1'b1;
    cyc(1);
    wdt_disable = 1'b0;
    chk("wdt_off", wdt_en, 16'h0000);
    wr(8'h02);
    cyc(2);
    chk("stop", {cpu_halt, osc_stop, periph_halt}, 16'h0007);
    irq_pending = 1'b1;
    cyc(4);
    chk("no_wake", cpu_halt, 16'h0001);
    irq_pending = 1'b0;
    irq_enable = 1'b0;
    other_rst = 1'b1;
    cyc(3);
    chk("rst", sys_rst_n, 16'h0000);
    other_rst = 1'b0;
    waitsys;
    chk("after", {power_up_cause_flag, vmon_en, wdt_en, cpu_halt}, 16'h0006);
    chk("pc0", program_counter, pmrc_pkg::PC_RESET);
    $display("test stop done");
    cld_en = 1'b1;
    wr(8'h02);
    // detector reset is a one-cycle pulse, so watch for it within a bound
    n = 0;
    while (sys_rst_n !== 1'b0 && n < 16) begin
      cyc(1);
      n++;
    end
    chk("cld", sys_rst_n, 16'h0000);
    chk("cld_time", 16'(n >= 10), 16'h0001);
    cld_en = 1'b0;
    waitsys;
    reg_stop_shutdown = 1'b1;
    wr(8'h02);
    wdt_fire = 1'b1;
    cyc(4);
    chk("shut", {sys_rst_n, cpu_halt}, 16'h0003);
    wdt_fire = 1'b0;
    press = 1'b1;
    cyc(4);
    chk("pin_rst", sys_rst_n, 16'h0000);
    press = 1'b0;
    reg_stop_shutdown = 1'b0;
    waitsys;
    $display("test stop_reset done");
    wr(8'h01);
    cyc(2);
    wdt_fire = 1'b1;
    cyc(3);
    chk("wdt", sys_rst_n, 16'h0000);
    wdt_fire = 1'b0;
    waitsys;
    chk("run", cpu_halt, 16'h0000);
    vmon_fail = 1'b1;
    cyc(3);
    chk("vpin", {rst_pin_oe, pin_n, sys_rst_n}, 16'h0004);
    vmon_fail = 1'b0;
    waitsys;
    chk("vrel", rst_pin_oe, 16'h0000);
    $display("test resets done");
    por;
    summarize;
  end
  initial begin
    #300000;
    failures++;
    summarize;
  end
endmodule
